// [rtl/pps_pin_mux.sv]
// Purpose: Pin function multiplexer for ten eight-bit general ports
// Assumes: Pad inputs already synchronous to CLK_SYS_IN
// Notes:   All outputs registered, so pad changes appear one clock later
`timescale 1ns/10ps
module pps_pin_mux
    import pps_pkg::*;
#(
    parameter int NUM_PORTS_P = NUM_PORTS
) (
    input  wire logic                                        CLK_SYS_IN,
    input  wire logic                                        RST_B_IN,
    input  wire logic [NUM_PORTS_P*PINS_PER_PORT-1:0]        PIN_IN,
    output logic      [NUM_PORTS_P*PINS_PER_PORT-1:0]        PIN_OUT,
    output logic      [NUM_PORTS_P*PINS_PER_PORT-1:0]        PIN_OE_OUT,
    input  wire logic                                        CFG_WE_IN,
    input  wire logic [PORT_IDX_W-1:0]                       CFG_PORT_IN,
    input  wire logic [PINS_PER_PORT*SEL_W-1:0]              CFG_SEL_IN,
    input  wire logic [PINS_PER_PORT-1:0]                    CFG_ALT_IN_EN_IN,
    input  wire logic [PINS_PER_PORT-1:0]                    CFG_INV_IN,
    input  wire logic [NUM_PORTS_P*PINS_PER_PORT-1:0]        ALT_OUT1_IN,
    input  wire logic [NUM_PORTS_P*PINS_PER_PORT-1:0]        ALT_OUT2_IN,
    input  wire logic [NUM_PORTS_P*PINS_PER_PORT-1:0]        ALT_OUT3_IN,
    output logic      [NUM_PORTS_P*PINS_PER_PORT-1:0]        GPIO_RD_OUT,
    output logic      [NUM_PORTS_P*PINS_PER_PORT-1:0]        DFLT_IN_OUT,
    output logic      [NUM_PORTS_P*PINS_PER_PORT-1:0]        ALT_IN_OUT,
    input  wire logic                                        BYTE_SEL_MODE_IN,
    input  wire logic                                        EXT_BUS_LOW_WRITE_STROBE_B_IN,
    input  wire logic                                        EXT_BUS_HIGH_WRITE_STROBE_B_IN,
    input  wire logic                                        EXT_BUS_LOW_BYTE_SELECT_B_IN,
    input  wire logic                                        EXT_BUS_HIGH_BYTE_SELECT_B_IN,
    output logic                                             EXT_BUS_LOW_PIN_B_OUT,
    output logic                                             EXT_BUS_HIGH_PIN_B_OUT,
    input  wire logic                                        EXT_BUS_ADDRESS_LATCH_IN,
    input  wire logic                                        LATCH_POL_INV_IN,
    output logic                                             EXT_BUS_ADDRESS_LATCH_OUT
);
    localparam int NP = NUM_PORTS_P * PINS_PER_PORT;

    pps_cfg_if #(.N(NP)) cfg ();

    pps_cfg_store #(
        .NUM_PORTS_P (NUM_PORTS_P)
    ) u_store (
        .clk_in    (CLK_SYS_IN),
        .rst_b_in  (RST_B_IN),
        .we_in     (CFG_WE_IN),
        .port_in   (CFG_PORT_IN),
        .sel_in    (CFG_SEL_IN),
        .alt_en_in (CFG_ALT_IN_EN_IN),
        .inv_in    (CFG_INV_IN),
        .cfg       (cfg.store)
    );

    // ==========================================================
    // Per-pin routing
    logic [NP-1:0] pin_drv;
    logic [NP-1:0] pin_oe;
    logic [NP-1:0] dflt_route;
    logic [NP-1:0] alt_route;

    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++) begin : g_pin
            logic in_pol;
            // Inversion applies to functional paths only; general input stays raw
            assign in_pol = PIN_IN[gi] ^ cfg.inv[gi];
            assign pin_oe[gi] = (cfg.sel[gi] != SEL_INPUT);
            assign pin_drv[gi] = cfg.inv[gi] ^
                ((cfg.sel[gi] == SEL_ALT_OUT1) ? ALT_OUT1_IN[gi] :
                 (cfg.sel[gi] == SEL_ALT_OUT2) ? ALT_OUT2_IN[gi] :
                 (cfg.sel[gi] == SEL_ALT_OUT3) ? ALT_OUT3_IN[gi] : RST_PIN_LEVEL);
            assign dflt_route[gi] = cfg.alt_in_en[gi] ? RST_PIN_LEVEL : in_pol;
            assign alt_route[gi]  = cfg.alt_in_en[gi] ? in_pol : RST_PIN_LEVEL;
        end
    endgenerate

    // ==========================================================
    // Pin side registers
    logic [NP-1:0] next_pin_out;
    logic [NP-1:0] next_pin_oe;
    logic [NP-1:0] next_gpio_rd;
    logic [NP-1:0] next_dflt_in;
    logic [NP-1:0] next_alt_in;

    always_comb begin
        // Undriven pins still show a defined low on PIN_OUT
        next_pin_out = pin_drv & pin_oe;
        next_pin_oe  = pin_oe;
        next_gpio_rd = PIN_IN;
        next_dflt_in = dflt_route;
        next_alt_in  = alt_route;
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            PIN_OUT     <= {NP{RST_PIN_LEVEL}};
            PIN_OE_OUT  <= {NP{RST_PIN_LEVEL}};
            GPIO_RD_OUT <= {NP{RST_PIN_LEVEL}};
            DFLT_IN_OUT <= {NP{RST_PIN_LEVEL}};
            ALT_IN_OUT  <= {NP{RST_PIN_LEVEL}};
        end else begin
            PIN_OUT     <= next_pin_out;
            PIN_OE_OUT  <= next_pin_oe;
            GPIO_RD_OUT <= next_gpio_rd;
            DFLT_IN_OUT <= next_dflt_in;
            ALT_IN_OUT  <= next_alt_in;
        end
    end

    // ==========================================================
    // External bus strobe pins
    logic next_low_pin;
    logic next_high_pin;
    logic next_latch;

    always_comb begin
        // Byte selects share the write strobe pads
        next_low_pin  = BYTE_SEL_MODE_IN ? EXT_BUS_LOW_BYTE_SELECT_B_IN
                                         : EXT_BUS_LOW_WRITE_STROBE_B_IN;
        next_high_pin = BYTE_SEL_MODE_IN ? EXT_BUS_HIGH_BYTE_SELECT_B_IN
                                         : EXT_BUS_HIGH_WRITE_STROBE_B_IN;
        next_latch    = EXT_BUS_ADDRESS_LATCH_IN ^ LATCH_POL_INV_IN;
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            EXT_BUS_LOW_PIN_B_OUT     <= STROBE_IDLE;
            EXT_BUS_HIGH_PIN_B_OUT    <= STROBE_IDLE;
            EXT_BUS_ADDRESS_LATCH_OUT <= RST_LATCH_OUT;
        end else begin
            EXT_BUS_LOW_PIN_B_OUT     <= next_low_pin;
            EXT_BUS_HIGH_PIN_B_OUT    <= next_high_pin;
            EXT_BUS_ADDRESS_LATCH_OUT <= next_latch;
        end
    end

    // ==========================================================
    // Checks
    logic cfg_touched;
    logic next_cfg_touched;

    always_comb begin
        next_cfg_touched = cfg_touched | CFG_WE_IN;
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            cfg_touched <= RST_CFG_SEEN;
        end else begin
            cfg_touched <= next_cfg_touched;
        end
    end

    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!RST_B_IN);

    sequence wr_pin0_out;
        CFG_WE_IN && (CFG_PORT_IN == '0) && (CFG_SEL_IN[SEL_W-1:0] != SEL_INPUT)
        ##1 !CFG_WE_IN;
    endsequence

    sequence wr_pin0_in;
        CFG_WE_IN && (CFG_PORT_IN == '0) && (CFG_SEL_IN[SEL_W-1:0] == SEL_INPUT)
        ##1 !CFG_WE_IN;
    endsequence

    chk_hiz_until_write: assert property (!cfg_touched |-> PIN_OE_OUT == '0)
        else $error("pin driven before any configuration write");

    chk_gpio_read_path: assert property ($past(RST_B_IN) |-> GPIO_RD_OUT == $past(PIN_IN))
        else $error("general input does not follow pin level");

    chk_default_route: assert property (
        $past(RST_B_IN) && $past(!cfg.alt_in_en[0])
        |-> DFLT_IN_OUT[0] == $past(PIN_IN[0] ^ cfg.inv[0]) && !ALT_IN_OUT[0])
        else $error("default input route lost on pin 0");

    chk_alt_in_route: assert property (
        $past(RST_B_IN) && $past(cfg.alt_in_en[1])
        |-> ALT_IN_OUT[1] == $past(PIN_IN[1] ^ cfg.inv[1]) && !DFLT_IN_OUT[1])
        else $error("alternate input not routed on pin 1");

    chk_alt_out2_sel: assert property (
        $past(RST_B_IN) && $past(cfg.sel[0] == SEL_ALT_OUT2)
        |-> PIN_OUT[0] == $past(ALT_OUT2_IN[0] ^ cfg.inv[0]) && PIN_OE_OUT[0])
        else $error("alternate output 2 not on pin 0");

    chk_write_to_oe: assert property (wr_pin0_out |=> PIN_OE_OUT[0])
        else $error("output select did not enable driver");

    chk_write_to_hiz: assert property (wr_pin0_in |=> !PIN_OE_OUT[0] && !PIN_OUT[0])
        else $error("input select left driver on");

    chk_byte_sel_mux: assert property (
        $past(RST_B_IN) && $past(BYTE_SEL_MODE_IN)
        |-> EXT_BUS_LOW_PIN_B_OUT == $past(EXT_BUS_LOW_BYTE_SELECT_B_IN)
            && EXT_BUS_HIGH_PIN_B_OUT == $past(EXT_BUS_HIGH_BYTE_SELECT_B_IN))
        else $error("byte selects not on strobe pins");

    chk_latch_polarity: assert property (
        $past(RST_B_IN) && $past(LATCH_POL_INV_IN)
        |-> EXT_BUS_ADDRESS_LATCH_OUT != $past(EXT_BUS_ADDRESS_LATCH_IN))
        else $error("address latch polarity not inverted");
endmodule

// [rtl/pps_pkg.sv]
// Purpose: Shared constants for the port pin function selector
// Assumes: Ten ports of eight pins each
// Notes:   Selection codes are two bits per pin
package pps_pkg;
    // ==========================================================
    // Geometry
    localparam int NUM_PORTS     = 10;
    localparam int PINS_PER_PORT = 8;
    localparam int NUM_PINS      = NUM_PORTS * PINS_PER_PORT;
    localparam int PORT_IDX_W    = 4;
    localparam int SEL_W         = 2;

    // ==========================================================
    // Per-pin function selection codes
    localparam logic [SEL_W-1:0] SEL_INPUT    = 2'h0;
    localparam logic [SEL_W-1:0] SEL_ALT_OUT1 = 2'h1;
    localparam logic [SEL_W-1:0] SEL_ALT_OUT2 = 2'h2;
    localparam logic [SEL_W-1:0] SEL_ALT_OUT3 = 2'h3;

    // ==========================================================
    // Reset values
    localparam logic RST_SEL_BIT    = 1'h0;
    localparam logic RST_ALT_EN     = 1'h0;
    localparam logic RST_INV        = 1'h0;
    localparam logic RST_PIN_LEVEL  = 1'h0;
    localparam logic STROBE_IDLE    = 1'h1;
    localparam logic RST_LATCH_OUT  = 1'h0;
    localparam logic RST_CFG_SEEN   = 1'h0;
endpackage

// [rtl/pps_cfg_if.sv]
// Purpose: Per-pin configuration bundle between store and multiplexer
// Assumes: Store drives, multiplexer only reads
// Notes:   Packed arrays indexed by flat pin number port*8+bit
`timescale 1ns/10ps
interface pps_cfg_if #(
    parameter int N = 80
);
    logic [N-1:0][1:0] sel;
    logic [N-1:0]      alt_in_en;
    logic [N-1:0]      inv;

    modport store (output sel, output alt_in_en, output inv);
    modport mux   (input sel, input alt_in_en, input inv);
endinterface

// [rtl/pps_cfg_store.sv]
// Purpose: Holds the function selection of every port pin
// Assumes: One port of eight pins is written per strobe
// Notes:   Writes to a port index past the last port are dropped
`timescale 1ns/10ps
module pps_cfg_store
    import pps_pkg::*;
#(
    parameter int NUM_PORTS_P = NUM_PORTS
) (
    input  wire logic                            clk_in,
    input  wire logic                            rst_b_in,
    input  wire logic                            we_in,
    input  wire logic [PORT_IDX_W-1:0]           port_in,
    input  wire logic [PINS_PER_PORT*SEL_W-1:0]  sel_in,
    input  wire logic [PINS_PER_PORT-1:0]        alt_en_in,
    input  wire logic [PINS_PER_PORT-1:0]        inv_in,
    pps_cfg_if.store                             cfg
);
    localparam int NP = NUM_PORTS_P * PINS_PER_PORT;

    logic [NP-1:0][SEL_W-1:0] sel;
    logic [NP-1:0][SEL_W-1:0] next_sel;
    logic [NP-1:0]            alt_en;
    logic [NP-1:0]            next_alt_en;
    logic [NP-1:0]            inv;
    logic [NP-1:0]            next_inv;

    // ==========================================================
    // Write decode
    always_comb begin
        next_sel    = sel;
        next_alt_en = alt_en;
        next_inv    = inv;
        if (we_in && (port_in < PORT_IDX_W'(NUM_PORTS_P))) begin
            for (int b = 0; b < PINS_PER_PORT; b++) begin
                next_sel[int'(port_in) * PINS_PER_PORT + b]    = sel_in[b*SEL_W +: SEL_W];
                next_alt_en[int'(port_in) * PINS_PER_PORT + b] = alt_en_in[b];
                next_inv[int'(port_in) * PINS_PER_PORT + b]    = inv_in[b];
            end
        end
    end

    // Every pin comes out of reset as a plain input
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sel    <= {NP*SEL_W{RST_SEL_BIT}};
            alt_en <= {NP{RST_ALT_EN}};
            inv    <= {NP{RST_INV}};
        end else begin
            sel    <= next_sel;
            alt_en <= next_alt_en;
            inv    <= next_inv;
        end
    end

    assign cfg.sel       = sel;
    assign cfg.alt_in_en = alt_en;
    assign cfg.inv       = inv;

    // ==========================================================
    // Checks
    chk_store_drop_bad: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        we_in && (port_in >= PORT_IDX_W'(NUM_PORTS_P)) |=> sel == $past(sel))
        else $error("store changed on write to missing port");
endmodule

// [verif/pps_pad_model.sv]
// Purpose: Board circuitry on the port pads, resolving each pad level
// Assumes: Outside driver always present, so no pad is ever left floating
// Notes:   Outside driver backs off whenever the block enables its driver
`timescale 1ns/10ps
module pps_pad_model
    import pps_pkg::*;
#(
    parameter int N = NUM_PINS
) (
    input  wire logic [N-1:0] pin_out_in,
    input  wire logic [N-1:0] pin_oe_in,
    input  wire logic [N-1:0] ext_val_in,
    output logic      [N-1:0] pin_level_out
);
    // ==========================================================
    // Pad resolution
    // No contention modelled: outside side yields to the block
    always_comb begin
        pin_level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_val_in);
    end
endmodule

// [verif/tb_pps_pin_mux.sv]
// Purpose: Self-checking bench for the port pin function selector
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Reference model mirrors the configuration and predicts every output
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end
module tb_pps_pin_mux;
    import pps_pkg::*;
    localparam int NP      = NUM_PINS;
    localparam int MAX_CYC = 4000;
    logic                  clk, rst_b, we, mode, pol, ale, ale_out;
    logic                  lws, hws, lbs, hbs, lo_pin, hi_pin, e_lo, e_hi, e_ale;
    logic [PORT_IDX_W-1:0] port;
    logic [15:0]           sel_w;
    logic [7:0]            ae_w, inv_w;
    logic [NP-1:0]         pin_lvl, pin_out, pin_oe, ext_val, a1, a2, a3;
    logic [NP-1:0]         gpio, dflt, altin, s_ae, s_inv;
    logic [NP-1:0]         e_gpio, e_oe, e_out, e_dflt, e_alt;
    logic [NP-1:0][1:0]    s_sel;
    int                    fail_count, n_checks, cyc;

    pps_pin_mux #(.NUM_PORTS_P(NUM_PORTS)) pps_pin_mux_i (
        .CLK_SYS_IN(clk), .RST_B_IN(rst_b), .PIN_IN(pin_lvl), .PIN_OUT(pin_out),
        .PIN_OE_OUT(pin_oe), .CFG_WE_IN(we), .CFG_PORT_IN(port), .CFG_SEL_IN(sel_w),
        .CFG_ALT_IN_EN_IN(ae_w), .CFG_INV_IN(inv_w), .ALT_OUT1_IN(a1),
        .ALT_OUT2_IN(a2), .ALT_OUT3_IN(a3), .GPIO_RD_OUT(gpio), .DFLT_IN_OUT(dflt),
        .ALT_IN_OUT(altin), .BYTE_SEL_MODE_IN(mode),
        .EXT_BUS_LOW_WRITE_STROBE_B_IN(lws), .EXT_BUS_HIGH_WRITE_STROBE_B_IN(hws),
        .EXT_BUS_LOW_BYTE_SELECT_B_IN(lbs), .EXT_BUS_HIGH_BYTE_SELECT_B_IN(hbs),
        .EXT_BUS_LOW_PIN_B_OUT(lo_pin), .EXT_BUS_HIGH_PIN_B_OUT(hi_pin),
        .EXT_BUS_ADDRESS_LATCH_IN(ale), .LATCH_POL_INV_IN(pol),
        .EXT_BUS_ADDRESS_LATCH_OUT(ale_out));

    pps_pad_model #(.N(NP)) pps_pad_model_i (
        .pin_out_in(pin_out), .pin_oe_in(pin_oe), .ext_val_in(ext_val),
        .pin_level_out(pin_lvl));

    // ==========================================================
    // Expectation helpers
    function automatic logic out_of(input logic [1:0] s, input logic v, x1, x2, x3);
        case (s)
            SEL_ALT_OUT1: return x1 ^ v;
            SEL_ALT_OUT2: return x2 ^ v;
            SEL_ALT_OUT3: return x3 ^ v;
            default:      return 1'b0;
        endcase
    endfunction

    function automatic logic [NP-1:0] rnd();
        return NP'({$urandom(), $urandom(), $urandom()});
    endfunction

    // ==========================================================
    // Reference model: config mirror plus registered outputs
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_sel <= '0; s_ae <= '0; s_inv <= '0;
            e_gpio <= '0; e_oe <= '0; e_out <= '0; e_dflt <= '0; e_alt <= '0;
            e_lo <= 1'b1; e_hi <= 1'b1; e_ale <= 1'b0;
        end else begin
            for (int i = 0; i < NP; i++) begin
                e_oe[i]   <= s_sel[i] != SEL_INPUT;
                e_out[i]  <= out_of(s_sel[i], s_inv[i], a1[i], a2[i], a3[i]);
                e_dflt[i] <= !s_ae[i] & (pin_lvl[i] ^ s_inv[i]);
                e_alt[i]  <= s_ae[i] & (pin_lvl[i] ^ s_inv[i]);
            end
            e_gpio <= pin_lvl;
            e_lo   <= mode ? lbs : lws;
            e_hi   <= mode ? hbs : hws;
            e_ale  <= ale ^ pol;
            // Ports past the last one are silently dropped
            if (we && int'(port) < NUM_PORTS) begin
                for (int b = 0; b < PINS_PER_PORT; b++) begin
                    s_sel[int'(port) * 8 + b] <= sel_w[2 * b +: 2];
                    s_ae[int'(port) * 8 + b]  <= ae_w[b];
                    s_inv[int'(port) * 8 + b] <= inv_w[b];
                end
            end
        end
    end

    // ==========================================================
    // Every-cycle comparison, after the edge has settled
    always @(posedge clk) begin
        #2;
        `CHK("pin_oe", e_oe, pin_oe)
        `CHK("gpio_rd", e_gpio, gpio)
        `CHK("dflt_in", e_dflt, dflt)
        `CHK("pin_out", e_out, pin_out)
        `CHK("alt_in", e_alt, altin)
        `CHK("strobe_pins", {e_lo, e_hi}, {lo_pin, hi_pin})
        `CHK("addr_latch", e_ale, ale_out)
    end

    // ==========================================================
    // Clock, timeout and closing
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == MAX_CYC) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic rand_cycle();
        @(posedge clk);
        #1;
        we = ($urandom() % 3) == 0;
        port = PORT_IDX_W'($urandom());
        sel_w = 16'($urandom());
        ae_w = 8'($urandom());
        inv_w = 8'($urandom());
        {a1, a2, a3, ext_val} = {rnd(), rnd(), rnd(), rnd()};
        {mode, lws, hws, lbs, hbs, ale, pol} = 7'($urandom());
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(68572));
        rst_b = 1'b0; we = 1'b0; port = '0; sel_w = '0; ae_w = '0; inv_w = '0;
        {a1, a2, a3} = {rnd(), rnd(), rnd()};
        ext_val = rnd();
        {mode, lws, hws, lbs, hbs, ale, pol} = 7'h1e;
        repeat (20) @(posedge clk);
        #1 rst_b = 1'b1;
        // Back-to-back writes, one code per index cycling through all four, on every index incl. dropped ones
        for (int p = 0; p < 16; p++) begin
            @(posedge clk);
            #1;
            we = 1'b1;
            port = PORT_IDX_W'(p);
            sel_w = {8{2'(p % 4)}};
            ae_w = (p % 2) ? 8'h0f : 8'h00;
            inv_w = 8'h5a;
            ext_val = rnd();
        end
        repeat (1500) rand_cycle();
        // Reset in mid-run must drop every pin back to undriven input
        @(posedge clk);
        #1 rst_b = 1'b0;
        repeat (3) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (500) rand_cycle();
        complete_run();
    end
endmodule
